// [common/fsm_pkg.sv]
// constants for the fault status and measure select register bank
package fsm_pkg;
  localparam logic [7:0] FSM_OFS_FAULT = 8'h21;
  localparam logic [7:0] FSM_OFS_OVCELL = 8'h22;
  localparam logic [7:0] FSM_OFS_UVCELL = 8'h23;
  localparam logic [7:0] FSM_OFS_PAR_A = 8'h24;
  localparam logic [7:0] FSM_OFS_PAR_B = 8'h25;
  localparam logic [7:0] FSM_OFS_MEAS = 8'h30;
  localparam int FSM_BIT_OVER = 0;
  localparam int FSM_BIT_UNDER = 1;
  localparam int FSM_BIT_CRC = 2;
  localparam int FSM_BIT_POR = 3;
  localparam int FSM_BIT_FORCE = 4;
  localparam int FSM_BIT_IFAULT = 5;
  localparam logic [7:0] FSM_FAULT_RST = 8'h00;
  localparam logic [7:0] FSM_MEAS_RST = 8'h00;
  localparam logic [7:0] FSM_MEAS_WMASK = 8'h7F;
  localparam int FSM_BIT_KEEPON = 6;
  localparam int FSM_TEMP_LSB = 4;
  localparam int FSM_BIT_AUX = 3;
  localparam logic [2:0] FSM_CELLS_MAX = 3'h5;
  // reference settling time in ns and its cycle count at 125 MHz
  localparam int FSM_SETTLE_NS = 1000;
  localparam int FSM_CLK_NS = 8;
  localparam int FSM_SETTLE_CYC = (FSM_SETTLE_NS + FSM_CLK_NS - 1) / FSM_CLK_NS;
  localparam int FSM_CONV_CYC = 8;
  typedef enum logic [2:0] {
    FSM_ST_IDLE = 3'b001,
    FSM_ST_SETTLE = 3'b010,
    FSM_ST_CONV = 3'b100
  } fsm_state_t;
endpackage

// [verilog/fsm_bank.sv]
// fault status and measurement control register bank
module fsm_bank
  import fsm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port from the link decoder
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // events from the monitor core, same clock
  input wire logic consist_fail,
  input wire logic load_done,
  input wire logic crc_error,
  input wire logic [5:0] cell_over,
  input wire logic [5:0] cell_under,
  input wire logic [7:0] parity_first,
  input wire logic [3:0] parity_second,
  input wire logic conv_start,
  // converter control
  output logic conv_power,
  output logic conv_busy,
  output logic [1:0] temp_sel,
  output logic aux_sel,
  output logic [5:0] cell_mask,
  // fault pin
  output logic fault_out
);
  typedef struct packed {
    logic [7:0] fault;
    logic [5:0] over_bits;
    logic [5:0] under_bits;
    logic [7:0] meas;
    logic [7:0] rdata;
    fsm_state_t state;
    logic [7:0] cnt;
    logic [1:0] temp_lat;
    logic aux_lat;
    logic [5:0] mask_lat;
  } fsm_s_t;

  fsm_s_t s_reg, s_next;

  function automatic logic [5:0] cells_of(input logic [2:0] code);
    logic [5:0] m;
    m = 6'h01;
    if (code <= FSM_CELLS_MAX) begin
      m = 6'(({1'b0, 6'h00} | 7'h7F) >> (3'd6 - code)) & 6'h3F;
    end
    return m;
  endfunction

  logic wr_fault;
  assign wr_fault = wr_en && (addr == FSM_OFS_FAULT);

  always_comb begin
    s_next = s_reg;
    // set wins over host clear
    if (wr_fault) begin
      s_next.fault = s_reg.fault & ~(wdata & 8'h2F);
      s_next.fault[FSM_BIT_FORCE] = wdata[FSM_BIT_FORCE];
    end
    if (consist_fail) s_next.fault[FSM_BIT_IFAULT] = 1'b1;
    if (load_done) s_next.fault[FSM_BIT_POR] = 1'b1;
    if (crc_error) s_next.fault[FSM_BIT_CRC] = 1'b1;
    if (|cell_under) s_next.fault[FSM_BIT_UNDER] = 1'b1;
    if (|cell_over) s_next.fault[FSM_BIT_OVER] = 1'b1;
    s_next.over_bits = cell_over;
    s_next.under_bits = cell_under;
    if (wr_en && addr == FSM_OFS_MEAS) begin
      // top bit held zero even if the host misbehaves
      s_next.meas = wdata & FSM_MEAS_WMASK;
    end
    s_next.rdata = 8'h00;
    if (rd_en) begin
      unique case (addr)
        FSM_OFS_FAULT: s_next.rdata = s_reg.fault;
        FSM_OFS_OVCELL: s_next.rdata = {2'b00, s_reg.over_bits};
        FSM_OFS_UVCELL: s_next.rdata = {2'b00, s_reg.under_bits};
        FSM_OFS_PAR_A: s_next.rdata = parity_first;
        FSM_OFS_PAR_B: s_next.rdata = {4'h0, parity_second};
        FSM_OFS_MEAS: s_next.rdata = s_reg.meas;
        default: s_next.rdata = 8'h00;
      endcase
    end
    unique case (s_reg.state)
      FSM_ST_IDLE: begin
        if (conv_start) begin
          // selection is latched at sequence start
          s_next.temp_lat = s_reg.meas[FSM_TEMP_LSB +: 2];
          s_next.aux_lat = s_reg.meas[FSM_BIT_AUX];
          s_next.mask_lat = cells_of(s_reg.meas[2:0]);
          if (s_reg.meas[FSM_BIT_KEEPON]) begin
            s_next.state = FSM_ST_CONV;
            s_next.cnt = 8'(FSM_CONV_CYC - 1);
          end else begin
            s_next.state = FSM_ST_SETTLE;
            s_next.cnt = 8'(FSM_SETTLE_CYC - 1);
          end
        end
      end
      FSM_ST_SETTLE: begin
        if (s_reg.cnt == 8'h00) begin
          s_next.state = FSM_ST_CONV;
          s_next.cnt = 8'(FSM_CONV_CYC - 1);
        end else begin
          s_next.cnt = s_reg.cnt - 8'h01;
        end
      end
      FSM_ST_CONV: begin
        if (s_reg.cnt == 8'h00) s_next.state = FSM_ST_IDLE;
        else s_next.cnt = s_reg.cnt - 8'h01;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg.fault <= FSM_FAULT_RST;
      s_reg.over_bits <= 6'h00;
      s_reg.under_bits <= 6'h00;
      s_reg.meas <= FSM_MEAS_RST;
      s_reg.rdata <= 8'h00;
      s_reg.state <= FSM_ST_IDLE;
      s_reg.cnt <= 8'h00;
      s_reg.temp_lat <= 2'b00;
      s_reg.aux_lat <= 1'b0;
      s_reg.mask_lat <= 6'h01;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;
  assign conv_power = s_reg.meas[FSM_BIT_KEEPON] || (s_reg.state != FSM_ST_IDLE);
  assign conv_busy = (s_reg.state == FSM_ST_CONV);
  assign temp_sel = s_reg.temp_lat;
  assign aux_sel = s_reg.aux_lat;
  assign cell_mask = s_reg.mask_lat;
  assign fault_out = |(s_reg.fault & 8'h3F);

  property p_force;
    @(posedge clk) disable iff (rst)
      wr_fault |=> (s_reg.fault[FSM_BIT_FORCE] == $past(wdata[FSM_BIT_FORCE]))
        && (fault_out || !s_reg.fault[FSM_BIT_FORCE]);
  endproperty
  a_force: assert property (p_force) else $error("force set but fault idle");

  property p_clear;
    @(posedge clk) disable iff (rst)
      (wr_fault && wdata[FSM_BIT_CRC] && !crc_error) |=> !s_reg.fault[FSM_BIT_CRC];
  endproperty
  a_clear: assert property (p_clear) else $error("crc flag not cleared");

  property p_sticky;
    @(posedge clk) disable iff (rst)
      (s_reg.fault[FSM_BIT_POR] && !(wr_fault && wdata[FSM_BIT_POR])) |=> s_reg.fault[FSM_BIT_POR];
  endproperty
  a_sticky: assert property (p_sticky) else $error("power-on flag lost");

  property p_ifault;
    @(posedge clk) disable iff (rst) consist_fail |=> s_reg.fault[FSM_BIT_IFAULT];
  endproperty
  a_ifault: assert property (p_ifault) else $error("consistency flag not set");

  property p_crc;
    @(posedge clk) disable iff (rst) crc_error |=> s_reg.fault[FSM_BIT_CRC];
  endproperty
  a_crc: assert property (p_crc) else $error("crc flag not set");

  property p_under;
    @(posedge clk) disable iff (rst)
      (|cell_under) |=> s_reg.fault[FSM_BIT_UNDER] && s_reg.under_bits == $past(cell_under);
  endproperty
  a_under: assert property (p_under) else $error("undervoltage not reported");

  property p_over;
    @(posedge clk) disable iff (rst)
      (|cell_over) |=> s_reg.fault[FSM_BIT_OVER] && s_reg.over_bits == $past(cell_over);
  endproperty
  a_over: assert property (p_over) else $error("overvoltage not reported");

  property p_parb;
    @(posedge clk) disable iff (rst) (rd_en && addr == FSM_OFS_PAR_B) |=> rdata[7:4] == 4'h0;
  endproperty
  a_parb: assert property (p_parb) else $error("parity upper bits nonzero");

  property p_auto_off;
    @(posedge clk) disable iff (rst)
      (s_reg.state == FSM_ST_IDLE && !s_reg.meas[FSM_BIT_KEEPON]) |-> !conv_power;
  endproperty
  a_auto_off: assert property (p_auto_off) else $error("converter on while idle");

  property p_cells;
    @(posedge clk) disable iff (rst)
      (s_reg.state == FSM_ST_IDLE && conv_start && s_reg.meas[2:0] > 3'h5) |=> cell_mask == 6'h01;
  endproperty
  a_cells: assert property (p_cells) else $error("illegal code not cell 1");

  property p_por;
    @(posedge clk) disable iff (rst) load_done |=> s_reg.fault[FSM_BIT_POR];
  endproperty
  a_por: assert property (p_por) else $error("power-on flag not set");

  property p_clr_over;
    @(posedge clk) disable iff (rst)
      (wr_fault && wdata[FSM_BIT_OVER] && !(|cell_over)) |=> !s_reg.fault[FSM_BIT_OVER];
  endproperty
  a_clr_over: assert property (p_clr_over) else $error("overvoltage flag not cleared");

  property p_clr_under;
    @(posedge clk) disable iff (rst)
      (wr_fault && wdata[FSM_BIT_UNDER] && !(|cell_under)) |=> !s_reg.fault[FSM_BIT_UNDER];
  endproperty
  a_clr_under: assert property (p_clr_under) else $error("undervoltage flag not cleared");

  property p_clr_por;
    @(posedge clk) disable iff (rst)
      (wr_fault && wdata[FSM_BIT_POR] && !load_done) |=> !s_reg.fault[FSM_BIT_POR];
  endproperty
  a_clr_por: assert property (p_clr_por) else $error("power-on flag not cleared");

  property p_clr_ifault;
    @(posedge clk) disable iff (rst)
      (wr_fault && wdata[FSM_BIT_IFAULT] && !consist_fail) |=> !s_reg.fault[FSM_BIT_IFAULT];
  endproperty
  a_clr_ifault: assert property (p_clr_ifault) else $error("consistency flag not cleared");

  property p_over_sticky;
    @(posedge clk) disable iff (rst)
      (s_reg.fault[FSM_BIT_OVER] && !(wr_fault && wdata[FSM_BIT_OVER])) |=> s_reg.fault[FSM_BIT_OVER];
  endproperty
  a_over_sticky: assert property (p_over_sticky) else $error("overvoltage flag lost");

  property p_pin_event;
    @(posedge clk) disable iff (rst) (crc_error || consist_fail || load_done) |=> fault_out;
  endproperty
  a_pin_event: assert property (p_pin_event) else $error("fault pin idle after event");

  property p_wr_meas;
    @(posedge clk) disable iff (rst)
      (wr_en && addr == FSM_OFS_MEAS) |=> s_reg.meas[6:0] == $past(wdata[6:0]) && !s_reg.meas[7];
  endproperty
  a_wr_meas: assert property (p_wr_meas) else $error("measure control write wrong");

  property p_settle;
    @(posedge clk) disable iff (rst)
      (s_reg.state == FSM_ST_IDLE && conv_start && !s_reg.meas[FSM_BIT_KEEPON]) |=> conv_power && !conv_busy;
  endproperty
  a_settle: assert property (p_settle) else $error("auto mode did not power up to settle");

  // auto mode: the settling wait always comes before the fixed conversion window
  property p_settle_len;
    @(posedge clk) disable iff (rst)
      (s_reg.state == FSM_ST_IDLE && conv_start && !s_reg.meas[FSM_BIT_KEEPON])
        |=> !conv_busy ##125 conv_busy [*8] ##1 !conv_busy;
  endproperty
  a_settle_len: assert property (p_settle_len) else $error("auto mode sequence timing wrong");

  property p_conv_len;
    @(posedge clk) disable iff (rst)
      (s_reg.state == FSM_ST_IDLE && conv_start && s_reg.meas[FSM_BIT_KEEPON]) |=> conv_busy [*8] ##1 !conv_busy;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("keep-on conversion timing wrong");

  // host may rewrite keep-on mid-conversion, so cycles with such a write are skipped
  property p_keepon;
    @(posedge clk) disable iff (rst)
      (s_reg.meas[FSM_BIT_KEEPON] && s_reg.state == FSM_ST_CONV && s_reg.cnt == 8'h00
        && !(wr_en && addr == FSM_OFS_MEAS)) |=> conv_power;
  endproperty
  a_keepon: assert property (p_keepon) else $error("keep-on converter powered down");

  property p_temp;
    @(posedge clk) disable iff (rst)
      (s_reg.state == FSM_ST_IDLE && conv_start) |=> temp_sel == $past(s_reg.meas[FSM_TEMP_LSB +: 2]);
  endproperty
  a_temp: assert property (p_temp) else $error("temperature selection not latched");

  property p_aux;
    @(posedge clk) disable iff (rst)
      (s_reg.state == FSM_ST_IDLE && conv_start) |=> aux_sel == $past(s_reg.meas[FSM_BIT_AUX]);
  endproperty
  a_aux: assert property (p_aux) else $error("aux input selection not latched");

  property p_mask;
    @(posedge clk) disable iff (rst)
      (s_reg.state == FSM_ST_IDLE && conv_start && s_reg.meas[2:0] <= FSM_CELLS_MAX)
        |=> $onehot({1'b0, cell_mask} + 7'h01) && $countones(cell_mask) == $past(s_reg.meas[2:0]) + 1;
  endproperty
  a_mask: assert property (p_mask) else $error("cell mask does not match code");

  property p_rd_fault;
    @(posedge clk) disable iff (rst)
      (rd_en && addr == FSM_OFS_FAULT) |=> rdata == $past(s_reg.fault);
  endproperty
  a_rd_fault: assert property (p_rd_fault) else $error("fault register read wrong");

  property p_para;
    @(posedge clk) disable iff (rst)
      (rd_en && addr == FSM_OFS_PAR_A) |=> rdata == $past(parity_first);
  endproperty
  a_para: assert property (p_para) else $error("first parity register read wrong");
endmodule // fsm_bank

// [dv/fsm_host.sv]
// host model driving the register port of the bank
module fsm_host
  import fsm_pkg::*;
(
  // clock
  input wire logic clk,
  // register port
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    addr = a;
    wdata = (a == FSM_OFS_MEAS) ? (d & 8'h7F) : d;
    wr_en = 1'b1;
    @(posedge clk) #1;
    wr_en = 1'b0;
    // released bus never shows a stale value
    addr = ~addr;
    wdata = ~wdata;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) #1;
    addr = a;
    rd_en = 1'b1;
    @(posedge clk) #1;
    rd_en = 1'b0;
    addr = ~addr;
    d = rdata;
  endtask
endmodule // fsm_host

// [dv/tb.sv]
// self-checking bench for the fault status register bank
module tb;
  import fsm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [7:0] e;} fsm_row_t;
  logic clk, rst, wr_en, rd_en, conv_start, conv_power, conv_busy, aux_sel, fault_out;
  logic [7:0] addr, wdata, rdata, parity_first, rd_val, m;
  logic [5:0] cell_over, cell_under, cell_mask;
  logic [3:0] parity_second;
  logic [2:0] ev;
  logic [1:0] temp_sel;
  int mismatches, samples_checked, cyc;
  fsm_row_t rows[7] = '{'{8'h22, 8'h2A}, '{8'h23, 8'h15}, '{8'h24, 8'hC3}, '{8'h25, 8'h0A},
                        '{8'h40, 8'h00}, '{8'h30, 8'h00}, '{8'h21, 8'h03}};
  logic [7:0] evb[3] = '{8'h04, 8'h08, 8'h20};
  fsm_host host_u (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata));
  fsm_bank dut_u (.clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
    .rdata(rdata), .consist_fail(ev[2]), .load_done(ev[1]), .crc_error(ev[0]), .cell_over(cell_over),
    .cell_under(cell_under), .parity_first(parity_first), .parity_second(parity_second),
    .conv_start(conv_start), .conv_power(conv_power), .conv_busy(conv_busy), .temp_sel(temp_sel),
    .aux_sel(aux_sel), .cell_mask(cell_mask), .fault_out(fault_out));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, rd_val);
    chk(rd_val, e);
  endtask
  // bounded waits: settling plus conversion is well under 250 cycles
  task automatic conv(input logic [7:0] v);
    int n;
    n = 0;
    host_u.wr(FSM_OFS_MEAS, v);
    chk({7'h0, conv_power}, {7'h0, v[6]});
    @(posedge clk) #1;
    conv_start = 1'b1;
    @(posedge clk) #1;
    conv_start = 1'b0;
    chk({7'h0, conv_power}, 8'h01);
    while (conv_busy !== 1'b1 && n < 200) begin
      @(posedge clk) #1;
      n++;
    end
    chk({7'h0, conv_busy}, 8'h01);
    while (conv_busy === 1'b1 && n < 250) begin
      @(posedge clk) #1;
      n++;
    end
    chk({7'h0, conv_power}, {7'h0, v[6]});
  endtask
  initial begin
    rst = 1'b1;
    conv_start = 1'b0;
    ev = 3'h0;
    cell_over = 6'h2A;
    cell_under = 6'h15;
    parity_first = 8'hC3;
    parity_second = 4'hA;
    mismatches = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    chk({7'h0, fault_out}, 8'h00);
    foreach (rows[i]) rchk(rows[i].a, rows[i].e);
    host_u.wr(FSM_OFS_OVCELL, 8'hFF);
    rchk(FSM_OFS_OVCELL, 8'h2A);
    cell_over = 6'h00;
    cell_under = 6'h00;
    rchk(FSM_OFS_FAULT, 8'h03);
    host_u.wr(FSM_OFS_FAULT, 8'h03);
    rchk(FSM_OFS_FAULT, 8'h00);
    chk({7'h0, fault_out}, 8'h00);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) #1;
      ev[i] = 1'b1;
      @(posedge clk) #1;
      ev[i] = 1'b0;
      rchk(FSM_OFS_FAULT, evb[i]);
      chk({7'h0, fault_out}, 8'h01);
      host_u.wr(FSM_OFS_FAULT, evb[i]);
      rchk(FSM_OFS_FAULT, 8'h00);
    end
    host_u.wr(FSM_OFS_FAULT, 8'h10);
    chk({7'h0, fault_out}, 8'h01);
    rchk(FSM_OFS_FAULT, 8'h10);
    host_u.wr(FSM_OFS_FAULT, 8'h00);
    chk({7'h0, fault_out}, 8'h00);
    for (int c = 0; c < 8; c++) begin
      m = {2'b01, c[1:0], c[0], c[2:0]};
      conv(m);
      chk({6'h0, temp_sel}, {6'h0, c[1:0]});
      chk({7'h0, aux_sel}, {7'h0, c[0]});
      chk({2'h0, cell_mask}, (c <= 5) ? ((8'h02 << c) - 8'h01) : 8'h01);
    end
    conv(8'h05);
    chk({2'h0, cell_mask}, 8'h3F);
    // event and host clear in one cycle: the event wins
    cell_under = 6'h01;
    fork
      host_u.wr(FSM_OFS_FAULT, 8'h06);
      begin
        @(posedge clk) #1;
        ev[0] = 1'b1;
        @(posedge clk) #1;
        ev[0] = 1'b0;
      end
    join
    rchk(FSM_OFS_FAULT, 8'h06);
    rchk(FSM_OFS_UVCELL, 8'h01);
    cell_under = 6'h00;
    host_u.wr(FSM_OFS_FAULT, 8'h06);
    rchk(FSM_OFS_FAULT, 8'h00);
    // mid-run reset returns the fault and measure control registers and the cell mask to their defaults
    host_u.wr(FSM_OFS_FAULT, 8'h10);
    host_u.wr(FSM_OFS_MEAS, 8'h75);
    @(posedge clk) #1;
    rst = 1'b1;
    @(posedge clk) #1;
    rst = 1'b0;
    chk({7'h0, fault_out}, 8'h00);
    chk({7'h0, conv_power}, 8'h00);
    chk({2'h0, cell_mask}, 8'h01);
    rchk(FSM_OFS_MEAS, 8'h00);
    finish_test();
  end
endmodule // tb
